// *** pkg/ssa_pkg.sv ***
// ssa_pkg: shared types and constants for the saturating simd alu
// assumes one core clock domain; operands come from the decode stage
package ssa_pkg;

  // ----------------------------------------------------------------
  // widths and register numbers
  // ----------------------------------------------------------------
  localparam int SSA_W = 32;
  localparam int SSA_HW = 16;
  localparam int SSA_BW = 8;
  localparam logic [3:0] SSA_REG_SP = 4'hd;
  localparam logic [3:0] SSA_REG_PC = 4'hf;
  localparam int SSA_CC_PASS_LATENCY = 1;

  // ----------------------------------------------------------------
  // status word layout
  // ----------------------------------------------------------------
  localparam int SSA_N_BIT = 31;
  localparam int SSA_Z_BIT = 30;
  localparam int SSA_C_BIT = 29;
  localparam int SSA_V_BIT = 28;
  localparam int SSA_Q_BIT = 27;
  localparam logic [31:0] SSA_STATUS_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // operations
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SSA_OP_NONE        = 4'h0,
    SSA_OP_ADD_WORD    = 4'h1,
    SSA_OP_SUB_WORD    = 4'h2,
    SSA_OP_ADD_HALVES  = 4'h3,
    SSA_OP_SUB_HALVES  = 4'h4,
    SSA_OP_ADD_BYTES   = 4'h5,
    SSA_OP_SUB_BYTES   = 4'h6,
    SSA_OP_ADD_SUB_X   = 4'h7,
    SSA_OP_SUB_ADD_X   = 4'h8,
    SSA_OP_DOUBLE_ADD  = 4'h9,
    SSA_OP_DOUBLE_SUB  = 4'ha,
    SSA_OP_UADD_SUB_X  = 4'hb,
    SSA_OP_USUB_ADD_X  = 4'hc,
    SSA_OP_STATUS_WR   = 4'hd,
    SSA_OP_STATUS_RD   = 4'he
  } ssa_op_e;

  // condition codes, standard sixteen-entry encoding
  typedef enum logic [3:0] {
    SSA_CC_EQ = 4'h0, SSA_CC_NE = 4'h1, SSA_CC_CS = 4'h2, SSA_CC_CC = 4'h3,
    SSA_CC_MI = 4'h4, SSA_CC_PL = 4'h5, SSA_CC_VS = 4'h6, SSA_CC_VC = 4'h7,
    SSA_CC_HI = 4'h8, SSA_CC_LS = 4'h9, SSA_CC_GE = 4'ha, SSA_CC_LT = 4'hb,
    SSA_CC_GT = 4'hc, SSA_CC_LE = 4'hd, SSA_CC_AL = 4'he, SSA_CC_NV = 4'hf
  } ssa_cond_e;

  typedef struct packed {
    logic valid;
    ssa_op_e op;
    ssa_cond_e cond;
    logic [3:0] rd;
    logic [31:0] opa;
    logic [31:0] opb;
  } ssa_req_s;

  typedef struct packed {
    logic wr_en;
    logic [3:0] rd;
    logic [31:0] data;
  } ssa_res_s;

endpackage

// *** rtl/ssa_lane.sv ***
// ssa_lane: one lane add or subtract with signed or unsigned clamp
// operands arrive unextended; the lane sign or zero extends them by two bits itself
module ssa_lane
  import ssa_pkg::*;
#(
  parameter int W = 8
) (
  // operands
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  input wire logic sub,
  input wire logic uns,
  // result
  output logic [W-1:0] y,
  output logic sat
);

  logic [W+1:0] ext_a;
  logic [W+1:0] ext_b;
  logic [W+1:0] raw;
  logic [W-1:0] smax;
  logic [W-1:0] smin;

  // extended precision, no carry leaves the lane
  always_comb begin
    ext_a = uns ? {2'b00, a} : {{2{a[W-1]}}, a};
    ext_b = uns ? {2'b00, b} : {{2{b[W-1]}}, b};
    raw = sub ? ext_a - ext_b : ext_a + ext_b;
    smax = {1'b0, {(W-1){1'b1}}};
    smin = {1'b1, {(W-1){1'b0}}};
    y = raw[W-1:0];
    sat = 1'b0;
    if (uns) begin
      if (raw[W+1]) begin
        y = '0;
        sat = 1'b1;
      end else if (raw[W]) begin
        y = '1;
        sat = 1'b1;
      end
    end else if (raw[W+1] && !(&raw[W:W-1])) begin
      y = smin;
      sat = 1'b1;
    end else if (!raw[W+1] && (|raw[W:W-1])) begin
      y = smax;
      sat = 1'b1;
    end
  end

endmodule

// *** rtl/ssa_cond.sv ***
// ssa_cond: condition code evaluation against n z c v
// assumes flags come from the status word of the same clock
module ssa_cond
  import ssa_pkg::*;
(
  // inputs
  input wire ssa_cond_e cond,
  input wire logic [3:0] nzcv,
  // result
  output logic pass
);

  logic n;
  logic z;
  logic c;
  logic v;

  always_comb begin
    n = nzcv[3];
    z = nzcv[2];
    c = nzcv[1];
    v = nzcv[0];
    case (cond)
      SSA_CC_EQ: pass = z;
      SSA_CC_NE: pass = !z;
      SSA_CC_CS: pass = c;
      SSA_CC_CC: pass = !c;
      SSA_CC_MI: pass = n;
      SSA_CC_PL: pass = !n;
      SSA_CC_VS: pass = v;
      SSA_CC_VC: pass = !v;
      SSA_CC_HI: pass = c && !z;
      SSA_CC_LS: pass = !c || z;
      SSA_CC_GE: pass = n == v;
      SSA_CC_LT: pass = n != v;
      SSA_CC_GT: pass = !z && (n == v);
      SSA_CC_LE: pass = z || (n != v);
      default: pass = 1'b1;
    endcase
  end

endmodule

// *** rtl/ssa_alu.sv ***
// ssa_alu: saturating simd datapath with sticky saturation flag
// assumes decode never names the stack pointer or program counter
// assumes one request per cycle in the core clock domain

module ssa_alu
  import ssa_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // request from decode
  input wire ssa_req_s req,
  // result to register file
  output ssa_res_s res,
  // status word and reserved register flag
  output logic [31:0] status_word,
  output logic bad_reg
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0] status_r;
  logic [31:0] status_nxt;
  ssa_res_s res_r;
  ssa_res_s res_nxt;

  logic pass;
  logic [31:0] result;
  logic sat_word;

  // ----------------------------------------------------------------
  // lane operand selection
  // ----------------------------------------------------------------
  logic [15:0] ha_lo;
  logic [15:0] hb_lo;
  logic [15:0] ha_hi;
  logic [15:0] hb_hi;
  logic h_sub_lo;
  logic h_sub_hi;
  logic h_uns;
  logic [15:0] hy_lo;
  logic [15:0] hy_hi;
  logic [7:0] by [4];
  logic byte_sub;

  logic [31:0] wa;
  logic [31:0] wb;
  logic w_sub;
  logic [31:0] wy;
  logic ws;
  logic [31:0] dy;
  logic ds;

  always_comb begin
    ha_lo = req.opa[15:0];
    hb_lo = req.opb[15:0];
    ha_hi = req.opa[31:16];
    hb_hi = req.opb[31:16];
    h_sub_lo = 1'b0;
    h_sub_hi = 1'b0;
    h_uns = 1'b0;
    case (req.op)
      SSA_OP_SUB_HALVES: begin
        h_sub_lo = 1'b1;
        h_sub_hi = 1'b1;
      end
      SSA_OP_ADD_SUB_X, SSA_OP_UADD_SUB_X: begin
        hb_hi = req.opb[15:0];
        hb_lo = req.opb[31:16];
        h_sub_lo = 1'b1;
        h_uns = req.op == SSA_OP_UADD_SUB_X;
      end
      SSA_OP_SUB_ADD_X, SSA_OP_USUB_ADD_X: begin
        hb_hi = req.opb[15:0];
        hb_lo = req.opb[31:16];
        h_sub_hi = 1'b1;
        h_uns = req.op == SSA_OP_USUB_ADD_X;
      end
      default: begin
      end
    endcase
  end

  ssa_lane #(.W(SSA_HW)) u_half_lo (
    .a(ha_lo),
    .b(hb_lo),
    .sub(h_sub_lo),
    .uns(h_uns),
    .y(hy_lo),
    .sat()
  );

  ssa_lane #(.W(SSA_HW)) u_half_hi (
    .a(ha_hi),
    .b(hb_hi),
    .sub(h_sub_hi),
    .uns(h_uns),
    .y(hy_hi),
    .sat()
  );

  // ----------------------------------------------------------------
  // byte lanes
  // ----------------------------------------------------------------
  assign byte_sub = req.op == SSA_OP_SUB_BYTES;

  for (genvar i = 0; i < 4; i++) begin : g_byte
    ssa_lane #(.W(SSA_BW)) u_byte (
      .a(req.opa[i*8 +: 8]),
      .b(req.opb[i*8 +: 8]),
      .sub(byte_sub),
      .uns(1'b0),
      .y(by[i]),
      .sat()
    );
  end

  // ----------------------------------------------------------------
  // word path, doubling stage feeds the add/sub stage
  // ----------------------------------------------------------------
  ssa_lane #(.W(SSA_W)) u_double (
    .a(req.opb),
    .b(req.opb),
    .sub(1'b0),
    .uns(1'b0),
    .y(dy),
    .sat(ds)
  );

  always_comb begin
    wa = req.opa;
    wb = req.opb;
    w_sub = req.op == SSA_OP_SUB_WORD;
    if (req.op == SSA_OP_DOUBLE_ADD || req.op == SSA_OP_DOUBLE_SUB) begin
      wb = dy;
      w_sub = req.op == SSA_OP_DOUBLE_SUB;
    end
  end

  ssa_lane #(.W(SSA_W)) u_word (
    .a(wa),
    .b(wb),
    .sub(w_sub),
    .uns(1'b0),
    .y(wy),
    .sat(ws)
  );

  // ----------------------------------------------------------------
  // condition check
  // ----------------------------------------------------------------
  ssa_cond u_cond (
    .cond(req.cond),
    .nzcv(status_r[SSA_N_BIT:SSA_V_BIT]),
    .pass(pass)
  );

  // ----------------------------------------------------------------
  // result and sticky flag
  // ----------------------------------------------------------------
  always_comb begin
    result = '0;
    sat_word = 1'b0;
    case (req.op)
      SSA_OP_ADD_WORD, SSA_OP_SUB_WORD: begin
        result = wy;
        sat_word = ws;
      end
      SSA_OP_DOUBLE_ADD, SSA_OP_DOUBLE_SUB: begin
        result = wy;
        sat_word = ws || ds;
      end
      SSA_OP_ADD_HALVES, SSA_OP_SUB_HALVES, SSA_OP_ADD_SUB_X, SSA_OP_SUB_ADD_X,
      SSA_OP_UADD_SUB_X, SSA_OP_USUB_ADD_X: begin
        // lane clamps left unwired on purpose: they never reach the sticky flag
        result = {hy_hi, hy_lo};
      end
      SSA_OP_ADD_BYTES, SSA_OP_SUB_BYTES: begin
        result = {by[3], by[2], by[1], by[0]};
      end
      SSA_OP_STATUS_RD: result = status_r;
      default: result = '0;
    endcase
  end

  always_comb begin
    status_nxt = status_r;
    res_nxt = '0;
    if (req.valid && pass) begin
      if (req.op == SSA_OP_STATUS_WR) begin
        status_nxt = req.opa;
      end else if (sat_word) begin
        status_nxt[SSA_Q_BIT] = 1'b1;
      end
      // n z c v never come from the arithmetic path
      if (req.op != SSA_OP_NONE && req.op != SSA_OP_STATUS_WR) begin
        res_nxt.wr_en = 1'b1;
        res_nxt.rd = req.rd;
        res_nxt.data = result;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_r <= SSA_STATUS_RESET;
      res_r <= '0;
    end else begin
      status_r <= status_nxt;
      res_r <= res_nxt;
    end
  end

  assign res = res_r;
  assign status_word = status_r;
  // flags a decode slip only; the result is still written as asked
  assign bad_reg = req.valid && (req.rd == SSA_REG_SP || req.rd == SSA_REG_PC);

endmodule

// *** verif/ssa_alu_properties.sv ***
// ssa_alu_properties: port-level checks on the saturating alu
// assumes it is bound into ssa_alu with one clock and reset_n
module ssa_alu_checker
  import ssa_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // watched ports
  input wire ssa_req_s req,
  input wire ssa_res_s res,
  input wire logic [31:0] status_word,
  input wire logic bad_reg
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // helpers
  // ----
  logic [31:0] wsum;
  logic wr_req;
  logic lane_req;
  logic word_sat;
  logic eq_fail;
  assign wsum = req.opa + req.opb;
  assign wr_req = req.valid && req.op == SSA_OP_STATUS_WR;
  assign lane_req = req.valid && req.op inside {SSA_OP_ADD_HALVES, SSA_OP_SUB_HALVES, SSA_OP_ADD_BYTES,
    SSA_OP_SUB_BYTES};
  assign word_sat = req.valid && req.op == SSA_OP_ADD_WORD && req.cond == SSA_CC_AL
    && req.opa[31] == req.opb[31] && wsum[31] != req.opa[31];
  // z is clear, so an equal condition must fail
  assign eq_fail = req.valid && req.cond == SSA_CC_EQ && !status_word[SSA_Z_BIT];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // ----
  // assertions
  // ----
  res_cause_a: assert property (res.wr_en |-> $past(req.valid)
    && !($past(req.op) inside {SSA_OP_NONE, SSA_OP_STATUS_WR})) else $error("result without request");
  res_dest_a: assert property (res.wr_en |-> res.rd == $past(req.rd)) else $error("wrong destination");
  q_sticky_a: assert property ($fell(status_word[SSA_Q_BIT]) |-> $past(wr_req)) else $error("q cleared");
  flags_hold_a: assert property (!$past(wr_req) |-> $stable(status_word[31:28])) else $error("nzcv moved");
  lane_q_a: assert property ($past(lane_req) |-> $stable(status_word[SSA_Q_BIT])) else $error("lane set q");
  word_sat_a: assert property ($past(word_sat) |-> status_word[SSA_Q_BIT] && res.wr_en
    && res.data == ($past(req.opa[31]) ? 32'h80000000 : 32'h7fffffff)) else $error("word clamp");
  status_rd_a: assert property (res.wr_en && $past(req.op) == SSA_OP_STATUS_RD
    |-> res.data == $past(status_word)) else $error("status read");
  cond_fail_a: assert property ($past(eq_fail) |-> !res.wr_en ##1 !res.wr_en) else $error("cond fail wrote");
  no_bad_reg_a: assert property (!bad_reg) else $error("reserved register named");
  cover property ($past(word_sat));
  cover property ($past(lane_req));
  cover property ($fell(status_word[SSA_Q_BIT]));
endmodule

bind ssa_alu ssa_alu_checker ssa_alu_checker_inst (.sys_clk(sys_clk), .reset_n(reset_n), .req(req), .res(res),
  .status_word(status_word), .bad_reg(bad_reg));

// *** verif/ssa_decode_model.sv ***
// ssa_decode_model: decode stage stand-in feeding the alu
// assumes the bench calls issue from one process only
module ssa_decode_model
  import ssa_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // request out
  output ssa_req_s req
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] rd_r = 4'h0;
  initial req = '0;
  // ----
  // one request per call, a gap cycle after it
  // ----
  task automatic issue(input ssa_op_e op, input ssa_cond_e cond, input logic [31:0] a, input logic [31:0] b);
    @(posedge sys_clk);
    rd_r <= (rd_r == 4'hc) ? 4'h0 : rd_r + 4'h1;
    req <= '{1'b1, op, cond, rd_r, a, b};
    @(posedge sys_clk);
    req.valid <= 1'b0;
  endtask
endmodule

// *** verif/ssa_alu_tb.sv ***
// ssa_alu_tb: directed checks of the saturating alu
// assumes the decode model drives req and the checker is bound
module ssa_alu_tb
  import ssa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam ssa_cond_e al = SSA_CC_AL;
  localparam logic [31:0] q = 32'h08000000;
  logic sys_clk;
  logic reset_n;
  ssa_req_s req;
  ssa_res_s res;
  logic [31:0] status_word;
  logic bad_reg;
  int mismatches;
  int checks_done;
  ssa_alu ssa_alu_inst (.sys_clk(sys_clk), .reset_n(reset_n), .req(req), .res(res), .status_word(status_word),
    .bad_reg(bad_reg));
  ssa_decode_model ssa_decode_model_inst (.sys_clk(sys_clk), .req(req));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // ----
  // shared tasks
  // ----
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic run(ssa_op_e op, ssa_cond_e cond, logic [31:0] a, logic [31:0] b, logic wr, logic [31:0] d,
    logic [31:0] st);
    ssa_decode_model_inst.issue(op, cond, a, b);
    #1;
    check("wr_en", {31'h0, res.wr_en}, {31'h0, wr});
    if (wr) begin
      check("data", res.data, d);
      check("rd", {28'h0, res.rd}, {28'h0, req.rd});
    end
    check("status", status_word, st);
  endtask
  task automatic t_reset();
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    #1;
    check("res wr_en", {31'h0, res.wr_en}, 32'h0);
    check("res data", res.data, 32'h0);
    check("status", status_word, SSA_STATUS_RESET);
    @(posedge sys_clk);
    reset_n <= 1'b1;
  endtask
  task automatic results();
    $display("mismatches %0d checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_word();
    run(SSA_OP_ADD_WORD, al, 32'h7fffffff, 32'h1, 1'h1, 32'h7fffffff, q);
    run(SSA_OP_ADD_WORD, al, 32'h5, 32'h3, 1'h1, 32'h8, q);
    run(SSA_OP_STATUS_RD, al, 32'h0, 32'h0, 1'h1, q, q);
    run(SSA_OP_STATUS_WR, al, 32'h0, 32'h0, 1'h0, 32'h0, 32'h0);
    run(SSA_OP_SUB_WORD, al, 32'h80000000, 32'h1, 1'h1, 32'h80000000, q);
    run(SSA_OP_STATUS_WR, al, 32'h0, 32'h0, 1'h0, 32'h0, 32'h0);
  endtask
  task automatic t_lanes();
    run(SSA_OP_ADD_HALVES, al, 32'h7fff8000, 32'h0001ffff, 1'h1, 32'h7fff8000, 32'h0);
    run(SSA_OP_SUB_HALVES, al, 32'h80000005, 32'h00010006, 1'h1, 32'h8000ffff, 32'h0);
    run(SSA_OP_ADD_BYTES, al, 32'h7f8001ff, 32'h01ff0101, 1'h1, 32'h7f800200, 32'h0);
    run(SSA_OP_SUB_BYTES, al, 32'h807f0010, 32'h01ff0120, 1'h1, 32'h807ffff0, 32'h0);
  endtask
  task automatic t_exch();
    run(SSA_OP_ADD_SUB_X, al, 32'h7fff8000, 32'h00010001, 1'h1, 32'h7fff8000, 32'h0);
    run(SSA_OP_SUB_ADD_X, al, 32'h7fff8000, 32'hffffffff, 1'h1, 32'h7fff8000, 32'h0);
    run(SSA_OP_UADD_SUB_X, al, 32'hffff0001, 32'h00020003, 1'h1, 32'hffff0000, 32'h0);
    run(SSA_OP_USUB_ADD_X, al, 32'h0001ffff, 32'h00030002, 1'h1, 32'h0000ffff, 32'h0);
  endtask
  // the second case only passes if doubling clamps before the add
  task automatic t_double();
    run(SSA_OP_DOUBLE_ADD, al, 32'h1, 32'h40000000, 1'h1, 32'h7fffffff, q);
    run(SSA_OP_STATUS_WR, al, 32'h0, 32'h0, 1'h0, 32'h0, 32'h0);
    run(SSA_OP_DOUBLE_ADD, al, 32'h80000000, 32'h40000000, 1'h1, 32'hffffffff, q);
    run(SSA_OP_STATUS_WR, al, 32'h0, 32'h0, 1'h0, 32'h0, 32'h0);
    run(SSA_OP_DOUBLE_SUB, al, 32'h0, 32'hc0000000, 1'h1, 32'h7fffffff, q);
    run(SSA_OP_STATUS_WR, al, 32'h0, 32'h0, 1'h0, 32'h0, 32'h0);
    run(SSA_OP_DOUBLE_SUB, al, 32'h10, 32'h3, 1'h1, 32'ha, 32'h0);
  endtask
  task automatic t_cond();
    run(SSA_OP_STATUS_WR, al, 32'h40000000, 32'h0, 1'h0, 32'h0, 32'h40000000);
    run(SSA_OP_ADD_WORD, SSA_CC_NE, 32'h7fffffff, 32'h1, 1'h0, 32'h0, 32'h40000000);
    run(SSA_OP_ADD_WORD, SSA_CC_EQ, 32'h7fffffff, 32'h1, 1'h1, 32'h7fffffff, 32'h48000000);
    run(SSA_OP_ADD_HALVES, SSA_CC_NV, 32'h1, 32'h1, 1'h1, 32'h2, 32'h48000000);
    run(SSA_OP_STATUS_RD, al, 32'h0, 32'h0, 1'h1, 32'h48000000, 32'h48000000);
    run(SSA_OP_STATUS_WR, al, 32'h0, 32'h0, 1'h0, 32'h0, 32'h0);
    run(SSA_OP_ADD_WORD, SSA_CC_EQ, 32'h7fffffff, 32'h1, 1'h0, 32'h0, 32'h0);
  endtask
  initial begin
    reset_n = 1'b0;
    mismatches = 0;
    checks_done = 0;
    t_reset();
    t_word();
    t_lanes();
    t_exch();
    t_double();
    t_cond();
    t_reset();
    results();
  end
endmodule
